// *** logic/amre_pkg.sv ***
// constants, field layouts and carrier types of the acl rule engine
// assumes one 125 MHz core clock shared with the parser and forwarding
// How it works
// - at most one action per packet
// - lowest action pointer wins among true entries
// - entries sharing one action are ORed
// - selected rules in one entry are ANDed
// - all sixteen rules evaluated; pointer picks 0..15
// - class zero disables the rule
// - class picks layer 2, 3 or 4
// - layer 2 option picks count, type, mac, both
// - direction bit picks destination or source
// - polarity zero: mismatch true; one: equality true
// - count rule pairs with action at same index
// - eleven action bits form the count value
// - count rules never produce a forwarding action
// - time unit bit: microsecond or millisecond tick
// - countdown expiry without packet raises event
// - count-up hits terminal, raises event, then clears
// - layer 3: masked single or unmasked pair
// - address field holds chosen or source address
// - mask zero compares bit; pair mode holds destination
// - layer 4: protocol, tcp port, udp port, sequence
// - select mask bit n picks matching rule n
package amre_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned US_NS = 1000;
    localparam int unsigned US_CYC = (US_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;
    localparam int unsigned US_PER_MS = 1000;
    // match class and options
    localparam logic [1:0] CLS_OFF = 2'h0;
    localparam logic [1:0] CLS_L2 = 2'h1;
    localparam logic [1:0] CLS_L3 = 2'h2;
    localparam logic [1:0] CLS_L4 = 2'h3;
    localparam logic [1:0] L2_COUNT = 2'h0;
    localparam logic [1:0] L2_TYPE = 2'h1;
    localparam logic [1:0] L2_MAC = 2'h2;
    localparam logic [1:0] L3_MASKED = 2'h1;
    localparam logic [1:0] L3_PAIR = 2'h2;
    localparam logic [1:0] L4_PROTO = 2'h0;
    localparam logic [1:0] L4_TCP = 2'h1;
    localparam logic [1:0] L4_UDP = 2'h2;
    // field positions
    localparam int unsigned CTL_CLASS_LSB = 0;
    localparam int unsigned CTL_OPT_LSB = 2;
    localparam int unsigned CTL_DIR_BIT = 4;
    localparam int unsigned CTL_POL_BIT = 5;
    localparam int unsigned CTL_TYPE_LSB = 16;
    localparam int unsigned ACT_CNT_LSB = 0;
    localparam int unsigned ACT_TU_BIT = 11;
    localparam int unsigned ACT_CA_BIT = 12;
    localparam int unsigned PROC_PTR_LSB = 0;
    localparam int unsigned PROC_MASK_LSB = 16;
    // byte offsets; match entry n word k at MATCH_BASE + n*32 + k*4
    localparam logic [11:0] ADR_MATCH_BASE = 12'h000;
    localparam logic [11:0] ADR_ACTION_BASE = 12'h200;
    localparam logic [11:0] ADR_PROC_BASE = 12'h240;
    localparam logic [11:0] ADR_STATUS = 12'h280;
    localparam logic [11:0] ADR_LAST = 12'h284;
    localparam int unsigned MATCH_WORDS = 5;
    // writable bits per word; the rest read zero
    localparam logic [31:0] MASK_CTL = 32'hffff003f;
    localparam logic [31:0] MASK_MACHI = 32'h0000ffff;
    localparam logic [31:0] MASK_ACT = 32'hffff1fff;
    localparam logic [31:0] MASK_PROC = 32'hffff000f;
    localparam logic [31:0] MASK_FULL = 32'hffffffff;
    localparam logic [31:0] RST_WORD = 32'h00000000;

    typedef struct packed {
        logic valid;
        logic [47:0] dst_mac;
        logic [47:0] src_mac;
        logic [15:0] ethertype;
        logic [31:0] ip_src;
        logic [31:0] ip_dst;
        logic [7:0] protocol;
        logic is_tcp;
        logic is_udp;
        logic [15:0] l4_src;
        logic [15:0] l4_dst;
        logic [31:0] tcp_seq;
    } amre_hdr_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [3:0] index;
        logic [31:0] entry;
    } amre_act_t;
endpackage : amre_pkg

// *** logic/amre_engine.sv ***
// acl rule engine: sixteen matching rules, processing entries, actions
// assumes a parsed header strobe from same-clock logic, classic wishbone
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module amre_engine
    import amre_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // packet side
    input wire amre_hdr_t hdr_i,
    output amre_act_t act_o,
    output logic [15:0] count_event_o,
    output logic [15:0] count_status_o
);
    typedef struct packed {
        logic [15:0][MATCH_WORDS-1:0][31:0] mr;
        logic [15:0][31:0] ar;
        logic [15:0][31:0] pr;
        logic [15:0][10:0] cnt;
        logic [6:0] us_div;
        logic [9:0] ms_div;
        logic us_tick;
        logic ms_tick;
        logic [15:0] evt;
        logic [15:0] sts;
        logic ack;
        logic [31:0] dat;
        logic [5:0] last;
        amre_act_t act;
    } amre_state_t;

    amre_state_t state_ff;
    amre_state_t nxt_state;

    // returns {count_mode, result}
    function automatic logic [1:0] amre_eval(
        input logic [MATCH_WORDS-1:0][31:0] m,
        input amre_hdr_t h
    );
        logic [1:0] cls;
        logic [1:0] opt;
        logic dir;
        logic pol;
        logic [47:0] mac;
        logic [31:0] ip;
        logic [15:0] port;
        logic eq_mac;
        logic eq_type;
        logic raw;
        logic ok;
        cls = m[0][CTL_CLASS_LSB +: 2];
        opt = m[0][CTL_OPT_LSB +: 2];
        dir = m[0][CTL_DIR_BIT];
        pol = m[0][CTL_POL_BIT];
        mac = dir ? h.src_mac : h.dst_mac;
        ip = dir ? h.ip_src : h.ip_dst;
        port = dir ? h.l4_src : h.l4_dst;
        eq_mac = (mac == {m[2][15:0], m[1]});
        eq_type = (h.ethertype == m[0][CTL_TYPE_LSB +: 16]);
        raw = 1'b0;
        ok = 1'b1;
        case (cls)
            CLS_OFF:
            begin
                ok = 1'b0;
            end
            CLS_L2:
            begin
                case (opt)
                    L2_TYPE: raw = eq_type;
                    L2_MAC: raw = eq_mac;
                    default: raw = eq_mac && eq_type;
                endcase
            end
            CLS_L3:
            begin
                case (opt)
                    L3_MASKED: raw = ((ip ^ m[3]) & ~m[4]) == 32'h0;
                    L3_PAIR: raw = (h.ip_src == m[3]) &&
                        (h.ip_dst == m[4]);
                    default: ok = 1'b0;
                endcase
            end
            default:
            begin
                case (opt)
                    L4_PROTO: raw = h.protocol == m[3][7:0];
                    L4_TCP: raw = h.is_tcp && (port == m[3][15:0]);
                    L4_UDP: raw = h.is_udp && (port == m[3][15:0]);
                    default: raw = h.is_tcp && (h.tcp_seq == m[3]);
                endcase
            end
        endcase
        return {cls == CLS_L2 && opt == L2_COUNT,
            ok && (pol ? raw : !raw)};
    endfunction : amre_eval

    // merges byte lanes, then clears bits that do not exist
    function automatic logic [31:0] amre_merge(
        input logic [31:0] old,
        input logic [31:0] wr,
        input logic [3:0] sel,
        input logic [31:0] keep
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        return res & keep;
    endfunction : amre_merge

    always_comb
    begin
        logic [1:0] ev;
        logic [15:0] rule_hit;
        logic [15:0] cnt_hit;
        logic [15:0] cnt_mode;
        logic [15:0] ent_true;
        logic [15:0] act_true;
        logic [15:0] msk;
        logic [3:0] ptr;
        logic found;
        logic [3:0] win;
        logic [10:0] cv;
        logic tick;
        logic req;
        logic [3:0] ri;
        logic [2:0] wk;
        logic [31:0] rd;
        logic [15:0] clr;
        ev = 2'h0;
        rule_hit = 16'h0;
        cnt_hit = 16'h0;
        cnt_mode = 16'h0;
        ent_true = 16'h0;
        act_true = 16'h0;
        msk = 16'h0;
        ptr = 4'h0;
        found = 1'b0;
        win = 4'h0;
        cv = 11'h0;
        tick = 1'b0;
        rd = RST_WORD;
        clr = 16'h0;
        nxt_state = state_ff;
        req = wb_cyc_i && wb_stb_i;
        ri = wb_adr_i[8:5];
        wk = wb_adr_i[4:2];

        // every rule looks at every packet
        for (int r = 0; r < 16; r++)
        begin
            ev = amre_eval(state_ff.mr[r], hdr_i);
            cnt_mode[r] = ev[1];
            cnt_hit[r] = ev[1] && ev[0];
            rule_hit[r] = !ev[1] && ev[0];
        end
        for (int e = 0; e < 16; e++)
        begin
            msk = state_ff.pr[e][PROC_MASK_LSB +: 16];
            ptr = state_ff.pr[e][PROC_PTR_LSB +: 4];
            // an empty mask selects nothing and never fires
            ent_true[e] = (msk != 16'h0) && ((rule_hit & msk) == msk);
            act_true[ptr] = act_true[ptr] | ent_true[e];
        end
        // walk down so the lowest pointer is the one left standing
        for (int p = 15; p >= 0; p--)
        begin
            if (act_true[p])
            begin
                found = 1'b1;
                win = 4'(p);
            end
        end
        nxt_state.act.valid = hdr_i.valid;
        nxt_state.act.hit = hdr_i.valid && found;
        // idle cycles show no action, so idle bus junk never leaks out
        nxt_state.act.index = (hdr_i.valid && found) ? win : 4'h0;
        nxt_state.act.entry = (hdr_i.valid && found) ? state_ff.ar[win] :
            RST_WORD;
        // software sees the last real result, not the idle cycle after it
        if (state_ff.act.valid)
        begin
            nxt_state.last = {state_ff.act.hit, state_ff.act.valid,
                state_ff.act.index};
        end

        // microsecond and millisecond ticks
        nxt_state.us_tick = 1'b0;
        nxt_state.ms_tick = 1'b0;
        if (state_ff.us_div == 7'(US_CYC - 1))
        begin
            nxt_state.us_div = 7'h0;
            nxt_state.us_tick = 1'b1;
        end
        else
        begin
            nxt_state.us_div = state_ff.us_div + 7'h1;
        end
        if (state_ff.us_tick)
        begin
            if (state_ff.ms_div == 10'(US_PER_MS - 1))
            begin
                nxt_state.ms_div = 10'h0;
                nxt_state.ms_tick = 1'b1;
            end
            else
            begin
                nxt_state.ms_div = state_ff.ms_div + 10'h1;
            end
        end

        // counters, paired with the action entry of the same index
        nxt_state.evt = 16'h0;
        for (int r = 0; r < 16; r++)
        begin
            cv = state_ff.ar[r][ACT_CNT_LSB +: 11];
            tick = state_ff.ar[r][ACT_TU_BIT] ? state_ff.ms_tick :
                state_ff.us_tick;
            if (!cnt_mode[r])
            begin
                nxt_state.cnt[r] = 11'h0;
            end
            else if (state_ff.ar[r][ACT_CA_BIT])
            begin
                if (hdr_i.valid && cnt_hit[r])
                begin
                    if (state_ff.cnt[r] + 11'h1 == cv)
                    begin
                        nxt_state.cnt[r] = 11'h0;
                        nxt_state.evt[r] = 1'b1;
                    end
                    else
                    begin
                        nxt_state.cnt[r] = state_ff.cnt[r] + 11'h1;
                    end
                end
            end
            else if (hdr_i.valid && cnt_hit[r])
            begin
                nxt_state.cnt[r] = cv;
            end
            else if (tick && state_ff.cnt[r] != 11'h0)
            begin
                nxt_state.cnt[r] = state_ff.cnt[r] - 11'h1;
                nxt_state.evt[r] = state_ff.cnt[r] == 11'h1;
            end
        end

        // wishbone: ack one cycle after the request, writes commit
        // on the edge where the master sees ack
        nxt_state.ack = req && !state_ff.ack;
        if (wb_adr_i < ADR_ACTION_BASE)
        begin
            rd = (wk < 3'(MATCH_WORDS)) ? state_ff.mr[ri][wk] : RST_WORD;
        end
        else if (wb_adr_i < ADR_PROC_BASE)
        begin
            rd = state_ff.ar[wb_adr_i[5:2]];
        end
        else if (wb_adr_i < ADR_STATUS)
        begin
            rd = state_ff.pr[wb_adr_i[5:2]];
        end
        else if (wb_adr_i == ADR_STATUS)
        begin
            rd = {16'h0, state_ff.sts};
        end
        else if (wb_adr_i == ADR_LAST)
        begin
            rd = {26'h0, state_ff.last};
        end
        nxt_state.dat = (req && !state_ff.ack) ? rd : RST_WORD;
        if (req && state_ff.ack && wb_we_i)
        begin
            if (wb_adr_i < ADR_ACTION_BASE)
            begin
                if (wk < 3'(MATCH_WORDS))
                begin
                    nxt_state.mr[ri][wk] = amre_merge(state_ff.mr[ri][wk],
                        wb_dat_i, wb_sel_i, (wk == 3'h0) ? MASK_CTL :
                        (wk == 3'h2) ? MASK_MACHI : MASK_FULL);
                end
            end
            else if (wb_adr_i < ADR_PROC_BASE)
            begin
                nxt_state.ar[wb_adr_i[5:2]] = amre_merge(
                    state_ff.ar[wb_adr_i[5:2]], wb_dat_i, wb_sel_i, MASK_ACT);
            end
            else if (wb_adr_i < ADR_STATUS)
            begin
                nxt_state.pr[wb_adr_i[5:2]] = amre_merge(
                    state_ff.pr[wb_adr_i[5:2]], wb_dat_i, wb_sel_i,
                    MASK_PROC);
            end
            else if (wb_adr_i == ADR_STATUS)
            begin
                clr = 16'(amre_merge(RST_WORD, wb_dat_i, wb_sel_i,
                    MASK_FULL));
            end
        end
        // a new event outranks a clear in the same cycle
        nxt_state.sts = (state_ff.sts & ~clr) | state_ff.evt;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign wb_dat_o = state_ff.dat;
    assign wb_ack_o = state_ff.ack;
    assign act_o = state_ff.act;
    assign count_event_o = state_ff.evt;
    assign count_status_o = state_ff.sts;
endmodule : amre_engine
`default_nettype wire

// *** tb/amre_props.sv ***
// port checker for the acl rule engine
// assumes it is bound to amre_engine; one clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module amre_props
    import amre_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus and packet side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire amre_hdr_t hdr_i,
    input wire amre_act_t act_o,
    input wire logic [15:0] count_event_o,
    input wire logic [15:0] count_status_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence wb_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence wb_answer;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_timing_a: assert property (wb_take |=> wb_answer)
        else $error("ack not one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    act_answer_a: assert property (hdr_i.valid |=> act_o.valid)
        else $error("no result after header");
    act_cause_a: assert property (act_o.valid |-> $past(hdr_i.valid))
        else $error("result without header");
    hit_valid_a: assert property (act_o.hit |-> act_o.valid)
        else $error("hit outside result cycle");
    miss_zero_a: assert property (act_o.valid && !act_o.hit |->
        act_o.index == 4'h0 && act_o.entry == 32'h0)
        else $error("miss carries action data");
    status_set_a: assert property (count_event_o != 16'h0 |=>
        (count_status_o & $past(count_event_o)) == $past(count_event_o))
        else $error("event not held in status");
    status_cause_a: assert property ((count_status_o &
        ~$past(count_status_o) & ~$past(count_event_o)) == 16'h0)
        else $error("status set without event");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o
        && act_o == '0 && count_event_o == 16'h0)
        else $error("outputs busy after reset");
endmodule : amre_props
`default_nettype wire

// *** tb/amre_parser_model.sv ***
// parser side model: passes one header per strobe to the engine
// assumes the bench sets req_i just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module amre_parser_model
    import amre_pkg::*;
(
    // clock
    input wire logic clk_i,
    // bench request and header out
    input wire amre_hdr_t req_i,
    output amre_hdr_t hdr_o
);
    logic [$bits(amre_hdr_t)-2:0] idle_ff = '0;
    // idle fields toggle so a stale header never looks valid data
    always @(posedge clk_i)
    begin
        idle_ff <= ~idle_ff;
    end
    // valid is the top bit and stays low between strobes
    assign hdr_o = req_i.valid ? req_i : amre_hdr_t'({1'b0, idle_ff});
endmodule : amre_parser_model
`default_nettype wire

// *** tb/amre_engine_bench.sv ***
// bench for the acl rule engine: wishbone tasks and packet runs
// assumes amre_engine, the parser model and one 125 MHz clock
`timescale 1ns/10ps
`default_nettype none
module amre_engine_bench;
    import amre_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [11:0] adr = 12'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    amre_hdr_t req = '0;
    amre_hdr_t hdr;
    amre_act_t act;
    logic [15:0] ev;
    logic [15:0] sts;
    logic [3:0] sel = 4'h0;
    logic [3:0] lanes = 4'hf;
    int num_errors = 0;
    int n_checks = 0;
    amre_hdr_t pk [6];
    logic [4:0] ex [6];
    logic [15:0] xev [6];
    logic [47:0] ma = 48'h0a1b2c3d4e5f;
    logic [47:0] mc = 48'h02aabbccdd01;
    logic [31:0] procs [9] = '{32'h00030005, 32'h00040003, 32'h00080003,
        32'h00100007, 32'h00200008, 32'h00400009, 32'h00110002, 32'h00800000,
        32'h00000001};
    amre_parser_model u_model (.clk_i(clk_i), .req_i(req), .hdr_o(hdr));
    amre_engine dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .hdr_i(hdr),
        .act_o(act), .count_event_o(ev), .count_status_o(sts));
    always #4 clk_i = ~clk_i;
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize
    task automatic chk_word(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk_word
    // miss code 5'h10; a hit carries the word written to that action
    task automatic chk_act(input logic [4:0] p);
        logic [37:0] e;
        e = p[4] ? {2'b10, 36'h0} : {2'b11, p[3:0], 12'h00a, p[3:0], 16'h0};
        n_checks++;
        if (act !== e)
        begin
            num_errors++;
            $display("BAD action exp %h got %h", e, act);
        end
    endtask : chk_act
    task automatic wb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= lanes;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 40);
        q = rdat;
        if (ack !== 1'b1)
        begin
            num_errors++;
            summarize();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk_word("register", e, q);
    endtask : rd
    task automatic mrule(input int n, input logic [31:0] c,
        input logic [47:0] m, input logic [31:0] x, input logic [31:0] y);
        logic [11:0] b;
        b = ADR_MATCH_BASE + 12'(n * 32);
        wr(b, c);
        wr(b + 12'h4, m[31:0]);
        wr(b + 12'h8, {16'h0, m[47:32]});
        wr(b + 12'hc, x);
        wr(b + 12'h10, y);
    endtask : mrule
    function automatic amre_hdr_t mk(input logic [47:0] d,
        input logic [47:0] s, input logic [15:0] t, input logic [31:0] ip,
        input logic [15:0] p);
        mk = '0;
        mk.valid = 1'b1;
        mk.dst_mac = d;
        mk.src_mac = s;
        mk.ethertype = t;
        mk.ip_src = ip;
        mk.is_tcp = 1'b1;
        mk.l4_dst = p;
    endfunction : mk
    // headers go back to back, each result is checked a cycle later
    task automatic run(input int cnt);
        for (int i = 0; i <= cnt; i++)
        begin
            @(posedge clk_i);
            req <= (i < cnt) ? pk[i] : '0;
            if (i > 0)
            begin
                #1;
                chk_act(ex[i - 1]);
                chk_word("event", {16'h0, xev[i - 1]}, {16'h0, ev});
            end
        end
        @(posedge clk_i);
    endtask : run
    initial
    begin
        int n;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(ADR_STATUS, 32'h0);
        rd(12'h1e0, 32'h0);
        wr(12'h1e0, 32'hffffffff);
        rd(12'h1e0, MASK_CTL);
        lanes = 4'h1;
        wr(12'h1e0, 32'h0);
        lanes = 4'hf;
        rd(12'h1e0, 32'hffff0000);
        wr(12'h27c, 32'hffffffff);
        rd(12'h27c, MASK_PROC);
        wr(12'h300, 32'hffffffff);
        rd(12'h300, 32'h0);
        rd(12'h014, 32'h0);
        for (int k = 0; k < 16; k++)
            wr(ADR_ACTION_BASE + 12'(k * 4), {12'h00a, 4'(k), 16'h0});
        for (int k = 0; k < 9; k++)
            wr(ADR_PROC_BASE + 12'(k * 4), procs[k]);
        mrule(0, 32'h00000029, ma, 32'h0, 32'h0);
        mrule(1, 32'h08000025, 48'h0, 32'h0, 32'h0);
        mrule(2, 32'h00000036, 48'h0, 32'hc0a80100, 32'h000000ff);
        mrule(3, 32'h00000027, 48'h0, 32'h00000050, 32'h0);
        mrule(4, 32'h00000002, 48'h0, 32'h0, 32'h0);
        mrule(5, 32'h00000020, 48'h0, 32'h0, 32'h0);
        mrule(6, 32'h00000009, 48'h1, 32'h0, 32'h0);
        for (int k = 7; k < 11; k++)
            if (k != 9)
                mrule(k, 32'h88b50021, mc, 32'h0, 32'h0);
        wr(ADR_ACTION_BASE + 12'h1c, 32'h00001003);
        wr(ADR_ACTION_BASE + 12'h20, 32'h00000002);
        wr(ADR_ACTION_BASE + 12'h28, 32'h00000801);
        pk[0] = mk(ma, 48'h0, 16'h0800, 32'hc0a801ab, 16'h0050);
        pk[1] = mk(ma, 48'h0, 16'h0800, 32'h0a000001, 16'h0051);
        pk[2] = mk(ma, 48'h0, 16'h86dd, 32'h0a000001, 16'h0050);
        pk[3] = mk(48'h1, ma, 16'h86dd, 32'h0, 16'h0);
        pk[4] = mk(48'h2, ma, 16'h0800, 32'h0, 16'h0);
        pk[5] = mk(ma, 48'h0, 16'h0800, 32'hc0a80001, 16'h0051);
        ex = '{5'h03, 5'h05, 5'h03, 5'h10, 5'h09, 5'h05};
        xev = '{default: 16'h0};
        run(6);
        rd(ADR_LAST, 32'h00000035);
        mrule(9, 32'h0000002a, 48'h0, 32'h0a000001, 32'h0a000002);
        mrule(11, 32'h0000003b, 48'h0, 32'h00000035, 32'h0);
        mrule(12, 32'h00000023, 48'h0, 32'h00000011, 32'h0);
        wr(ADR_PROC_BASE + 12'h24, 32'h1a000004);
        pk[0] = mk(48'h2, 48'h0, 16'h0800, 32'h0a000001, 16'h0);
        pk[0].ip_dst = 32'h0a000002;
        pk[0].protocol = 8'h11;
        pk[0].is_tcp = 1'b0;
        pk[0].is_udp = 1'b1;
        pk[0].l4_src = 16'h0035;
        pk[1] = pk[0];
        pk[1].l4_src = 16'h0036;
        ex[0] = 5'h04;
        ex[1] = 5'h09;
        run(2);
        for (int k = 0; k < 3; k++)
            pk[k] = mk(mc, 48'h0, 16'h88b5, 32'h0, 16'h0);
        ex = '{default: 5'h09};
        xev[2] = 16'h0080;
        run(3);
        rd(ADR_STATUS, 32'h00000080);
        chk_word("status pin", 32'h00000080, {16'h0, sts});
        wr(ADR_STATUS, 32'h0000ffff);
        rd(ADR_STATUS, 32'h0);
        xev[0] = 16'h0;
        repeat (2)
        begin
            repeat (100) @(posedge clk_i);
            run(1);
        end
        n = 0;
        while (ev[8] !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        chk_word("expiry", 32'h1, {31'h0, n >= 120 && n <= 260});
        rd(ADR_STATUS, 32'h00000100);
        chk_word("status pin", 32'h00000100, {16'h0, sts});
        summarize();
    end
endmodule : amre_engine_bench
bind amre_engine amre_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .hdr_i(hdr_i), .act_o(act_o),
    .count_event_o(count_event_o), .count_status_o(count_status_o));
`default_nettype wire
